/* File: verilog/tpg_gpio.sv */
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RL1: the timer port has four bits, each input or output, shared with timer in and out signals.
// RL2: timer port bits 0 and 1 with direction 0 are inputs feeding the timer capture, 1 outputs.
// RL3: timer port bits 0 and 1 with function 0 drive the latch, with 1 drive the timer pulse.
// RL4: the timer pin input register returns the pin level for input bits and zero otherwise.
// RL5: the timer pin input register shows pins on bits 0 to 3 and zero above.
// RL6: the serial port has two bits, each input or output.
// RL7: serial bits in input pass the pin to receive, in output with function 1 drive transmit.
// RL8: software must also set up the serial selection logic to use the serial port.
// RL9: each serial bit selects push-pull drive with 0 and open-drain drive with 1.
// RL10: a serial latch 1 drives high in push-pull and releases the pin in open-drain.
// RL11: each serial bit has a software controlled pull-up.
// RL12: the pull-up acts only in input mode or open-drain output, and is off otherwise.
// RL13: a serial latch 0 drives low in output mode, and all control bits reset to zero.
// RL14: unimplemented upper register bits read zero and ignore writes.
module tpg_gpio (
    input wire logic clk_sys,
    input wire logic reset,
    input wire tpg_pkg::tpg_ahb_req_s ahb_req,
    output tpg_pkg::tpg_ahb_rsp_s ahb_rsp,
    input wire logic [tpg_pkg::T_W-1:0] timer_pin_in,
    output logic [tpg_pkg::T_W-1:0] timer_pin_out,
    output logic [tpg_pkg::T_W-1:0] timer_pin_oe_n,
    input wire logic pulse_gen_out_a,
    input wire logic pulse_gen_out_b,
    input wire logic pulse_width_out_a,
    input wire logic pulse_width_out_b,
    input wire logic [tpg_pkg::T_FN_W-1:0] pulse_width_sel,
    output logic timer_capture_in_a,
    output logic timer_capture_in_b,
    input wire logic [tpg_pkg::S_W-1:0] serial_pin_in,
    output logic [tpg_pkg::S_W-1:0] serial_pin_out,
    output logic [tpg_pkg::S_W-1:0] serial_pin_oe_n,
    output logic [tpg_pkg::S_W-1:0] serial_pullup_en,
    input wire logic [tpg_pkg::S_W-1:0] serial_transmit_out,
    output logic [tpg_pkg::S_W-1:0] serial_receive_in
);
    import tpg_pkg::*;

    typedef struct packed {
        logic [T_W-1:0] t_latch;
        logic [T_W-1:0] t_dir;
        logic [T_FN_W-1:0] t_fc;
        logic [S_W-1:0] s_latch;
        logic [S_W-1:0] s_dir;
        logic [S_W-1:0] s_fc;
        logic [S_W-1:0] s_od;
        logic [S_W-1:0] s_pu;
        logic wr_pend;
        logic [IDX_W-1:0] wr_idx;
        logic [31:0] rdata;
        logic ready;
        logic resp;
        logic [T_W-1:0] t_out;
        logic [T_W-1:0] t_oe_n;
        logic [T_FN_W-1:0] cap;
        logic [S_W-1:0] s_out;
        logic [S_W-1:0] s_oe_n;
        logic [S_W-1:0] s_pu_en;
        logic [S_W-1:0] rx;
    } tpg_state_s;

    tpg_state_s q;
    tpg_state_s n;

    logic [T_W+S_W-1:0] pins_sync;
    logic [T_W-1:0] t_sync;
    logic [S_W-1:0] s_sync;
    logic [T_FN_W-1:0] ppg_v;
    logic [T_FN_W-1:0] pwm_v;
    logic addr_ph;
    logic addr_ok;
    logic [IDX_W-1:0] addr_idx;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    tpg_pin_sync #(
        .WIDTH(T_W + S_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .pin_async({serial_pin_in, timer_pin_in}),
        .pin_sync(pins_sync)
    );

    assign t_sync = pins_sync[T_W-1:0];
    assign s_sync = pins_sync[T_W+S_W-1:T_W];
    assign ppg_v = {pulse_gen_out_b, pulse_gen_out_a};
    assign pwm_v = {pulse_width_out_b, pulse_width_out_a};

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode

    // misaligned or beyond the index range counts as unmapped
    function automatic logic addr_valid(input logic [31:0] a);
        addr_valid = (a[ADDR_LSB-1:0] == '0) && (a[31:ADDR_LSB+IDX_W] == '0);
    endfunction : addr_valid

    // read value; unmapped and upper bits give zero
    function automatic logic [31:0] rd_mux(input tpg_state_s s, input logic [IDX_W-1:0] idx,
                                           input logic [T_W-1:0] tp);
        rd_mux = WORD_ZERO;
        case (idx)
            IDX_T_LATCH: rd_mux[T_W-1:0] = s.t_latch;
            IDX_T_PIN: rd_mux[T_W-1:0] = tp & ~s.t_dir; // RL4 RL5
            IDX_T_DIR: rd_mux[T_W-1:0] = s.t_dir;
            IDX_T_FC: rd_mux[T_FN_W-1:0] = s.t_fc;
            IDX_S_LATCH: rd_mux[S_W-1:0] = s.s_latch;
            IDX_S_DIR: rd_mux[S_W-1:0] = s.s_dir;
            IDX_S_FC: rd_mux[S_W-1:0] = s.s_fc;
            IDX_S_DRV: rd_mux[S_W-1:0] = s.s_od;
            IDX_S_PU: rd_mux[S_W-1:0] = s.s_pu;
            default: rd_mux = WORD_ZERO; // RL14
        endcase
    endfunction : rd_mux

    assign addr_ph = ahb_req.hsel && ahb_req.htrans[HTRANS_ACT_BIT] && ahb_req.hready;
    assign addr_ok = addr_valid(ahb_req.haddr);
    assign addr_idx = ahb_req.haddr[ADDR_LSB+IDX_W-1:ADDR_LSB];

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        n = q;
        n.ready = 1'b1;
        n.resp = HRESP_OKAY;
        // write lands in the data phase; only the low bits are kept
        if (q.wr_pend) begin
            case (q.wr_idx)
                IDX_T_LATCH: n.t_latch = ahb_req.hwdata[T_W-1:0];
                IDX_T_DIR: n.t_dir = ahb_req.hwdata[T_W-1:0]; // RL1 RL2
                IDX_T_FC: n.t_fc = ahb_req.hwdata[T_FN_W-1:0]; // RL14
                IDX_S_LATCH: n.s_latch = ahb_req.hwdata[S_W-1:0];
                IDX_S_DIR: n.s_dir = ahb_req.hwdata[S_W-1:0]; // RL6
                IDX_S_FC: n.s_fc = ahb_req.hwdata[S_W-1:0];
                IDX_S_DRV: n.s_od = ahb_req.hwdata[S_W-1:0]; // RL9
                IDX_S_PU: n.s_pu = ahb_req.hwdata[S_W-1:0]; // RL11
                default: n.wr_pend = 1'b0;
            endcase
        end
        n.wr_pend = 1'b0;
        n.rdata = WORD_ZERO;
        if (addr_ph && addr_ok) begin
            if (ahb_req.hwrite) begin
                n.wr_pend = 1'b1;
                n.wr_idx = addr_idx;
            end else begin
                // reads after the pending write, so back-to-back sees new data
                n.rdata = rd_mux(n, addr_idx, t_sync);
            end
        end
        // timer port drive
        n.t_oe_n = ~q.t_dir; // RL2
        // bits above the function field stay plain port bits
        n.t_out = q.t_latch; // RL1
        for (int i = 0; i < T_FN_W; i++) begin
            if (q.t_fc[i]) begin
                n.t_out[i] = pulse_width_sel[i] ? pwm_v[i] : ppg_v[i]; // RL3
            end
        end
        n.cap = t_sync[T_FN_W-1:0] & ~q.t_dir[T_FN_W-1:0]; // RL2
        // serial port drive
        for (int i = 0; i < S_W; i++) begin
            n.s_out[i] = (q.s_fc[i] && q.s_dir[i]) ? serial_transmit_out[i] : q.s_latch[i]; // RL7
            // open drain never drives high, it only releases
            n.s_oe_n[i] = !q.s_dir[i] || (q.s_od[i] && n.s_out[i]); // RL10 RL13
            if (q.s_od[i]) begin
                n.s_out[i] = 1'b0; // RL9
            end
        end
        n.s_pu_en = q.s_pu & (~q.s_dir | q.s_od); // RL12
        n.rx = s_sync & ~q.s_dir; // RL7
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q <= '0; // RL13
            q.ready <= 1'b1;
            q.t_oe_n <= '1;
            q.s_oe_n <= '1;
        end else begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign ahb_rsp.hrdata = q.rdata;
    assign ahb_rsp.hreadyout = q.ready;
    assign ahb_rsp.hresp = q.resp;
    assign timer_pin_out = q.t_out;
    assign timer_pin_oe_n = q.t_oe_n;
    assign timer_capture_in_a = q.cap[0];
    assign timer_capture_in_b = q.cap[1];
    assign serial_pin_out = q.s_out;
    assign serial_pin_oe_n = q.s_oe_n;
    assign serial_pullup_en = q.s_pu_en;
    assign serial_receive_in = q.rx;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_wr_addr(logic [IDX_W-1:0] idx);
        addr_ph && addr_ok && ahb_req.hwrite && (addr_idx == idx);
    endsequence

    sequence s_rd_addr(logic [IDX_W-1:0] idx);
        addr_ph && addr_ok && !ahb_req.hwrite && (addr_idx == idx) && !q.wr_pend;
    endsequence

    property p_t_dir_oe;
        ##1 (timer_pin_oe_n == ~$past(q.t_dir));
    endproperty
    a_t_dir_oe: assert property (p_t_dir_oe) else $error("timer oe not following direction"); // RL2

    property p_capture;
        ##1 ({timer_capture_in_b, timer_capture_in_a} ==
             ($past(t_sync[T_FN_W-1:0]) & ~$past(q.t_dir[T_FN_W-1:0])));
    endproperty
    a_capture: assert property (p_capture) else $error("capture input wrong"); // RL2

    property p_t_pulse;
        (q.t_fc[0] && !pulse_width_sel[0]) |=> (timer_pin_out[0] == $past(pulse_gen_out_a));
    endproperty
    a_t_pulse: assert property (p_t_pulse) else $error("pulse not routed to timer pin"); // RL3

    property p_t_latch;
        !q.t_fc[1] |=> (timer_pin_out[1] == $past(q.t_latch[1]));
    endproperty
    a_t_latch: assert property (p_t_latch) else $error("timer latch not driven"); // RL3

    property p_pin_read;
        s_rd_addr(IDX_T_PIN) |=>
            (ahb_rsp.hrdata == {{(32-T_W){1'b0}}, $past(t_sync) & ~$past(q.t_dir)});
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin input read wrong"); // RL4 RL5

    property p_upper_zero;
        ahb_rsp.hrdata[31:T_W] == '0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero"); // RL14

    property p_dir_write;
        s_wr_addr(IDX_S_DIR) ##1 1'b1 |=> (q.s_dir == $past(ahb_req.hwdata[S_W-1:0]));
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("serial direction not written"); // RL6

    property p_rx;
        ##1 (serial_receive_in == ($past(s_sync) & ~$past(q.s_dir)));
    endproperty
    a_rx: assert property (p_rx) else $error("receive path wrong"); // RL7

    property p_od_release;
        (q.s_dir[0] && q.s_od[0] && !q.s_fc[0] && q.s_latch[0]) |=>
            (serial_pin_oe_n[0] && !serial_pin_out[0]);
    endproperty
    a_od_release: assert property (p_od_release) else $error("open drain drove high"); // RL10

    property p_pp_low;
        (q.s_dir[1] && !q.s_fc[1] && !q.s_latch[1]) |=>
            (!serial_pin_oe_n[1] && !serial_pin_out[1]);
    endproperty
    a_pp_low: assert property (p_pp_low) else $error("latch zero not driven low"); // RL13

    property p_pullup;
        ##1 (serial_pullup_en == ($past(q.s_pu) & (~$past(q.s_dir) | $past(q.s_od))));
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up enable wrong"); // RL12

    property p_t_plain;
        ##1 (timer_pin_out[T_W-1:T_FN_W] == $past(q.t_latch[T_W-1:T_FN_W]));
    endproperty
    a_t_plain: assert property (p_t_plain) else $error("plain timer bits wrong"); // RL1

    property p_s_tx;
        (q.s_dir[0] && q.s_fc[0] && !q.s_od[0]) |=>
            (!serial_pin_oe_n[0] && (serial_pin_out[0] == $past(serial_transmit_out[0])));
    endproperty
    a_s_tx: assert property (p_s_tx) else $error("transmit not routed to serial pin"); // RL7

    property p_od_low;
        ##1 ((serial_pin_out & $past(q.s_od)) == '0);
    endproperty
    a_od_low: assert property (p_od_low) else $error("open drain output high"); // RL9

    property p_latch_write;
        s_wr_addr(IDX_S_LATCH) ##1 1'b1 |=> (q.s_latch == $past(ahb_req.hwdata[S_W-1:0]));
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("serial latch not set"); // RL13

    property p_bus_okay;
        ahb_rsp.hreadyout && (ahb_rsp.hresp == HRESP_OKAY);
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or error"); // RL14

endmodule : tpg_gpio

`default_nettype wire

/* File: common/tpg_pkg.sv */
package tpg_pkg;

    // port widths
    localparam int T_W = 4;
    localparam int T_FN_W = 2;
    localparam int S_W = 2;

    // register indices; byte address is index times four
    localparam int IDX_W = 14;
    localparam int ADDR_LSB = 2;
    localparam logic [IDX_W-1:0] IDX_T_LATCH = 14'h0008;
    localparam logic [IDX_W-1:0] IDX_S_LATCH = 14'h0009;
    localparam logic [IDX_W-1:0] IDX_T_PIN = 14'h0015;
    localparam logic [IDX_W-1:0] IDX_T_DIR = 14'h0f22;
    localparam logic [IDX_W-1:0] IDX_S_DIR = 14'h0f23;
    localparam logic [IDX_W-1:0] IDX_S_PU = 14'h0f30;
    localparam logic [IDX_W-1:0] IDX_T_FC = 14'h0f3c;
    localparam logic [IDX_W-1:0] IDX_S_FC = 14'h0f3d;
    localparam logic [IDX_W-1:0] IDX_S_DRV = 14'h0f4a;

    // reset values
    localparam logic [T_W-1:0] T_RST = 4'h0;
    localparam logic [T_FN_W-1:0] T_FN_RST = 2'h0;
    localparam logic [S_W-1:0] S_RST = 2'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // ahb-lite encodings
    localparam int HTRANS_ACT_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } tpg_ahb_req_s;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } tpg_ahb_rsp_s;

endpackage : tpg_pkg

/* File: verilog/tpg_pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module tpg_pin_sync #(
    parameter int WIDTH = 6
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_sync
);
    import tpg_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } tpg_sync_s;

    tpg_sync_s q;
    tpg_sync_s d;

    // first stage feeds only the second
    always_comb begin
        d.meta = pin_async;
        d.stable = q.meta;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pin_sync = q.stable;

endmodule : tpg_pin_sync

`default_nettype wire

/* File: dv/tpg_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none

module tpg_pin_model (
    input wire logic clk_sys,
    input wire logic [tpg_pkg::T_W-1:0] timer_pin_out,
    input wire logic [tpg_pkg::T_W-1:0] timer_pin_oe_n,
    input wire logic [tpg_pkg::T_W-1:0] ext_t,
    input wire logic [tpg_pkg::S_W-1:0] serial_pin_out,
    input wire logic [tpg_pkg::S_W-1:0] serial_pin_oe_n,
    input wire logic [tpg_pkg::S_W-1:0] serial_pullup_en,
    input wire logic [tpg_pkg::S_W-1:0] ext_s,
    input wire logic [tpg_pkg::S_W-1:0] ext_s_en,
    output logic [tpg_pkg::T_W-1:0] timer_pin_in,
    output logic [tpg_pkg::S_W-1:0] serial_pin_in
);
    import tpg_pkg::*;
    logic float_q = 1'b0;
    ////////////////////////////////////////////////////////////////////////////////
    // a floating line changes every cycle so a stale value cannot pass
    always_ff @(posedge clk_sys) begin
        float_q <= ~float_q;
    end
    always_comb begin
        for (int i = 0; i < T_W; i++) begin
            timer_pin_in[i] = timer_pin_oe_n[i] ? ext_t[i] : timer_pin_out[i];
        end
        for (int i = 0; i < S_W; i++) begin
            if (!serial_pin_oe_n[i]) begin
                serial_pin_in[i] = serial_pin_out[i];
            end else if (ext_s_en[i]) begin
                serial_pin_in[i] = ext_s[i];
            end else begin
                serial_pin_in[i] = serial_pullup_en[i] | (float_q ^ i[0]);
            end
        end
    end
endmodule : tpg_pin_model

`default_nettype wire

/* File: dv/two_port_gpio_timer_serial_pins_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module two_port_gpio_timer_serial_pins_tb_top;
    import tpg_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    tpg_ahb_req_s rq = '0;
    tpg_ahb_rsp_s rsp;
    logic [T_W-1:0] t_in, t_out, t_oe_n, ext_t = 4'h0;
    logic pga = 1'b0, pgb = 1'b0, pwa = 1'b0, pwb = 1'b0, cap_a, cap_b;
    logic [S_W-1:0] pws = 2'h0, s_tx = 2'h0, ext_s = 2'h0, ext_s_en = 2'h0;
    logic [S_W-1:0] s_in, s_out, s_oe_n, s_pu, s_rx;
    int errors = 0;
    int n_checks = 0;
    logic [IDX_W-1:0] ridx [8] = '{IDX_T_LATCH, IDX_S_LATCH, IDX_T_DIR, IDX_S_DIR,
                                   IDX_S_PU, IDX_T_FC, IDX_S_FC, IDX_S_DRV};
    logic [31:0] rmsk [8] = '{32'h0000_000f, 32'h0000_0003, 32'h0000_000f, 32'h0000_0003,
                              32'h0000_0003, 32'h0000_0003, 32'h0000_0003, 32'h0000_0003};
    always #4 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    tpg_gpio i_tpg_gpio (.clk_sys(clk_sys), .reset(reset),
        .ahb_req(tpg_ahb_req_s'({rq[71:1], rsp.hreadyout})), .ahb_rsp(rsp),
        .timer_pin_in(t_in), .timer_pin_out(t_out), .timer_pin_oe_n(t_oe_n),
        .pulse_gen_out_a(pga), .pulse_gen_out_b(pgb), .pulse_width_out_a(pwa),
        .pulse_width_out_b(pwb), .pulse_width_sel(pws), .timer_capture_in_a(cap_a),
        .timer_capture_in_b(cap_b), .serial_pin_in(s_in), .serial_pin_out(s_out),
        .serial_pin_oe_n(s_oe_n), .serial_pullup_en(s_pu), .serial_transmit_out(s_tx),
        .serial_receive_in(s_rx));
    tpg_pin_model i_tpg_pin_model (.clk_sys(clk_sys), .timer_pin_out(t_out),
        .timer_pin_oe_n(t_oe_n), .ext_t(ext_t), .serial_pin_out(s_out),
        .serial_pin_oe_n(s_oe_n), .serial_pullup_en(s_pu), .ext_s(ext_s),
        .ext_s_en(ext_s_en), .timer_pin_in(t_in), .serial_pin_in(s_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // entered just after a rising edge, returns just after one
    task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        rq <= tpg_ahb_req_s'({1'b1, 16'h0000, idx, 2'b00, 2'b10, wr, 3'b010, 32'h0, 1'b0});
        do @(posedge clk_sys); while (rsp.hreadyout !== 1'b1);
        rq <= tpg_ahb_req_s'({1'b0, 32'h0, 2'b00, 1'b0, 3'b000, wd, 1'b0});
        do @(posedge clk_sys); while (rsp.hreadyout !== 1'b1);
        rd = rsp.hrdata;
    endtask : bus
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, idx, d, x);
    endtask : wr
    task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, idx, 32'h0000_0000, x);
        check(x, exp);
    endtask : rd_chk
    // covers sync flops plus output register with margin
    task automatic settle();
        repeat (5) @(posedge clk_sys);
    endtask : settle
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        errors++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 8; i++) rd_chk(ridx[i], WORD_ZERO);
        check(32'({t_oe_n, s_oe_n, s_pu}), 32'h0000_00fc);
        ext_t <= 4'ha;
        settle();
        rd_chk(IDX_T_PIN, 32'h0000_000a);
        check(32'({cap_b, cap_a}), 32'h0000_0002);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wr(ridx[i], 32'hffff_ffff);
            rd_chk(ridx[i], rmsk[i]);
        end
        wr(IDX_T_PIN, 32'hffff_ffff);
        rd_chk(IDX_T_PIN, WORD_ZERO);
        wr(14'h0100, 32'hffff_ffff);
        rd_chk(14'h0100, WORD_ZERO);
        for (int i = 0; i < 8; i++) wr(ridx[i], WORD_ZERO);
        $display("test registers done");
        wr(IDX_T_DIR, 32'h0000_0003);
        wr(IDX_T_LATCH, 32'h0000_0004);
        pwa <= 1'b1;
        pgb <= 1'b1;
        pws <= 2'b01;
        wr(IDX_T_FC, 32'h0000_0003);
        settle();
        check(32'(t_out[1:0]), 32'h0000_0003);
        check(32'(t_oe_n), 32'h0000_000c);
        check(32'({cap_b, cap_a}), WORD_ZERO);
        rd_chk(IDX_T_PIN, 32'h0000_0008);
        pws <= 2'b10;
        pga <= 1'b1;
        pwb <= 1'b1;
        pwa <= 1'b0;
        pgb <= 1'b0;
        settle();
        check(32'(t_out[1:0]), 32'h0000_0003);
        pga <= 1'b0;
        settle();
        check(32'(t_out[1:0]), 32'h0000_0002);
        wr(IDX_T_FC, WORD_ZERO);
        wr(IDX_T_DIR, 32'h0000_000f);
        settle();
        check(32'({t_oe_n, t_out}), 32'h0000_0004);
        rd_chk(IDX_T_PIN, WORD_ZERO);
        $display("test timer port done");
        wr(IDX_S_PU, 32'h0000_0003);
        ext_s <= 2'b10;
        ext_s_en <= 2'b11;
        settle();
        check(32'({s_oe_n, s_rx, s_pu}), 32'h0000_003b);
        ext_s_en <= 2'b00;
        wr(IDX_S_DIR, 32'h0000_0003);
        s_tx <= 2'b01;
        wr(IDX_S_FC, 32'h0000_0003);
        settle();
        check(32'({s_oe_n, s_out, s_rx, s_pu}), 32'h0000_0010);
        wr(IDX_S_FC, WORD_ZERO);
        wr(IDX_S_LATCH, 32'h0000_0002);
        settle();
        check(32'({s_oe_n, s_out, s_pu}), 32'h0000_0008);
        wr(IDX_S_DRV, 32'h0000_0003);
        settle();
        check(32'({s_oe_n, s_out, s_pu}), 32'h0000_0023);
        wr(IDX_S_LATCH, 32'h0000_0001);
        settle();
        check(32'({s_oe_n, s_out, s_pu}), 32'h0000_0013);
        $display("test serial port done");
        print_verdict();
    end
endmodule : two_port_gpio_timer_serial_pins_tb_top

`default_nettype wire
